/* pkg/fows_params.svh */
// timing figures and reset values for the flash/otp wait-state access block
// assumes the system clock figure below matches the real clock of the instance
`ifndef FOWS_PARAMS_SVH
`define FOWS_PARAMS_SVH

// system clock period in ns
`define FOWS_CLK_PERIOD_NS 10
// least array access times in ns
`define FOWS_PAGED_ACCESS_NS 36
`define FOWS_RANDOM_ACCESS_NS 36
`define FOWS_OTP_ACCESS_NS 60
// smallest wait-state count allowed per class
`define FOWS_PAGED_WS_FLOOR 0
`define FOWS_RANDOM_WS_FLOOR 1
`define FOWS_OTP_WS_FLOOR 1
// wait-states = ceil(t / period) - 1
`define FOWS_CEIL_WS(t) ((((t) + `FOWS_CLK_PERIOD_NS - 1) / `FOWS_CLK_PERIOD_NS) - 1)
// reset values
`define FOWS_COUNT_RST 4'h0
`define FOWS_READY_RST 1'b1

`endif

/* pkg/fows_pkg.sv */
// types shared by the flash/otp wait-state access block
// assumes nothing beyond a system verilog compiler
`default_nettype none
package fows_pkg;
    // width of every wait-state field
    localparam int WS_W = 4;
    typedef logic [WS_W-1:0] ws_t;
    // access classes, each with its own wait-state count
    typedef enum logic [1:0] {CLS_PAGED, CLS_RANDOM, CLS_OTP} access_class_t;
    // wait-state counts as configured by the host
    typedef struct packed {
        ws_t paged;
        ws_t random;
        ws_t otp;
    } ws_cfg_t;
    // per-class flags where the configured count is below the floor
    typedef struct packed {
        logic paged;
        logic random;
        logic otp;
    } ws_low_t;
endpackage
`default_nettype wire

/* rtl/flash_otp_wait_state_access.sv */
// read-access sequencer for flash and otp arrays with per-class wait-states
// assumes requests and configuration come from logic on the same clock
//
// Behaviour
// RULE_01: random flash wait-states never below one
// RULE_02: paged wait-states are ceil(t/period) minus one
// RULE_03: paged read gets at least 36 ns
// RULE_04: random read gets at least 36 ns
// RULE_05: otp read gets 60 ns, at least one
// RULE_06: host sets 3, 3, 5 at 100 MHz
// RULE_07: each otp location programmed only once
// RULE_08: reprogramming a flash sector needs prior erase
// RULE_09: read returns after wait-states plus one cycles
`include "fows_params.svh"
`default_nettype none
module flash_otp_wait_state_access #(
    parameter int ADDR_W = 22,
    parameter int DATA_W = 16,
    parameter int PAGE_BITS = 2
) (
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    input wire fows_pkg::ws_cfg_t WS_CFG_IN,
    input wire logic REQ_VALID_IN,
    input wire logic REQ_OTP_IN,
    input wire logic [ADDR_W-1:0] REQ_ADDR_IN,
    output logic REQ_READY_OUT,
    output logic ARRAY_EN_OUT,
    output logic ARRAY_OTP_OUT,
    output logic [ADDR_W-1:0] ARRAY_ADDR_OUT,
    input wire logic [DATA_W-1:0] ARRAY_DATA_IN,
    output logic RD_DONE_OUT,
    output logic [DATA_W-1:0] RD_DATA_OUT,
    output fows_pkg::access_class_t RD_CLASS_OUT,
    output fows_pkg::ws_low_t WS_LOW_OUT
);
    import fows_pkg::*;

    // refuse shapes that the page compare and counter cannot serve
    if (PAGE_BITS < 1 || PAGE_BITS >= ADDR_W || DATA_W < 1) begin : g_bad_shape
        $error("flash_otp_wait_state_access: bad ADDR_W, DATA_W or PAGE_BITS");
    end
    if (`FOWS_CEIL_WS(`FOWS_OTP_ACCESS_NS) > (1 << WS_W) - 1) begin : g_bad_ws
        $error("flash_otp_wait_state_access: wait-state field too narrow for clock");
    end

    typedef enum logic {S_IDLE, S_WAIT} state_t;

    // floors derived from the access times at this clock
    localparam int PAGED_CEIL = `FOWS_CEIL_WS(`FOWS_PAGED_ACCESS_NS);
    localparam int RANDOM_CEIL = `FOWS_CEIL_WS(`FOWS_RANDOM_ACCESS_NS);
    localparam int OTP_CEIL = `FOWS_CEIL_WS(`FOWS_OTP_ACCESS_NS);
    localparam ws_t PAGED_MIN = ws_t'((PAGED_CEIL > `FOWS_PAGED_WS_FLOOR) ?
        PAGED_CEIL : `FOWS_PAGED_WS_FLOOR); // [RULE_02] [RULE_03]
    localparam ws_t RANDOM_MIN = ws_t'((RANDOM_CEIL > `FOWS_RANDOM_WS_FLOOR) ?
        RANDOM_CEIL : `FOWS_RANDOM_WS_FLOOR); // [RULE_01] [RULE_04]
    localparam ws_t OTP_MIN = ws_t'((OTP_CEIL > `FOWS_OTP_WS_FLOOR) ?
        OTP_CEIL : `FOWS_OTP_WS_FLOOR); // [RULE_05]

    state_t state_reg, state_next;
    ws_t count_reg, count_next;
    logic ready_reg;
    logic array_en_reg;
    logic array_otp_reg;
    logic [ADDR_W-1:0] array_addr_reg;
    logic done_reg;
    logic [DATA_W-1:0] data_reg;
    access_class_t class_reg;
    ws_low_t ws_low_reg;
    logic page_valid_reg;
    logic [ADDR_W-PAGE_BITS-1:0] page_tag_reg;

    // class decode: a flash read in the last open page is a paged read
    wire take = REQ_VALID_IN && ready_reg;
    wire page_hit = page_valid_reg && (REQ_ADDR_IN[ADDR_W-1:PAGE_BITS] == page_tag_reg);
    wire access_class_t req_class = REQ_OTP_IN ? CLS_OTP : (page_hit ? CLS_PAGED : CLS_RANDOM);

    // a setting below the floor is raised to it: the array time is never cut short
    wire ws_t eff_paged = (WS_CFG_IN.paged < PAGED_MIN) ? PAGED_MIN : WS_CFG_IN.paged;
    wire ws_t eff_random = (WS_CFG_IN.random < RANDOM_MIN) ? RANDOM_MIN : WS_CFG_IN.random;
    wire ws_t eff_otp = (WS_CFG_IN.otp < OTP_MIN) ? OTP_MIN : WS_CFG_IN.otp;
    wire ws_t eff_ws = (req_class == CLS_OTP) ? eff_otp :
        ((req_class == CLS_PAGED) ? eff_paged : eff_random); // [RULE_01] [RULE_03] [RULE_04]

    // flags for a host setting below what the clock needs
    wire ws_low_t ws_low_next = '{paged: WS_CFG_IN.paged < PAGED_MIN,
        random: WS_CFG_IN.random < RANDOM_MIN, otp: WS_CFG_IN.otp < OTP_MIN}; // [RULE_06]

    // sequencer: load the count on a take, finish when it has run out
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        unique case (state_reg)
            S_IDLE: begin
                if (take) begin
                    state_next = S_WAIT;
                    count_next = eff_ws;
                end
            end
            S_WAIT: begin
                if (count_reg == `FOWS_COUNT_RST) begin
                    state_next = S_IDLE;
                end else begin
                    count_next = count_reg - ws_t'(1);
                end
            end
        endcase
    end

    wire finish = (state_reg == S_WAIT) && (count_reg == `FOWS_COUNT_RST);

    // state and counter
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            state_reg <= S_IDLE;
            count_reg <= `FOWS_COUNT_RST;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next; // [RULE_09]
        end
    end

    // requester stall and completion strobe; ready returns with done, so a new take can land in the done cycle
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            ready_reg <= `FOWS_READY_RST;
            done_reg <= 1'b0;
        end else begin
            ready_reg <= take ? 1'b0 : (finish ? 1'b1 : ready_reg); // [RULE_09]
            done_reg <= finish; // [RULE_09]
        end
    end

    // array drive held for the whole access, data caught in the last cycle
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            array_en_reg <= 1'b0;
            array_otp_reg <= 1'b0;
            array_addr_reg <= '0;
            data_reg <= '0;
            class_reg <= CLS_RANDOM;
        end else if (take) begin
            array_en_reg <= 1'b1;
            array_otp_reg <= REQ_OTP_IN;
            array_addr_reg <= REQ_ADDR_IN;
            class_reg <= req_class;
        end else if (finish) begin
            array_en_reg <= 1'b0;
            data_reg <= ARRAY_DATA_IN; // [RULE_09]
        end
    end

    // open-page tracking; an otp read leaves the flash page open
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            page_valid_reg <= 1'b0;
            page_tag_reg <= '0;
        end else if (take && !REQ_OTP_IN) begin
            page_valid_reg <= 1'b1;
            page_tag_reg <= REQ_ADDR_IN[ADDR_W-1:PAGE_BITS];
        end
    end

    // configuration check flags
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            ws_low_reg <= '0;
        end else begin
            ws_low_reg <= ws_low_next;
        end
    end

    assign REQ_READY_OUT = ready_reg;
    assign ARRAY_EN_OUT = array_en_reg;
    assign ARRAY_OTP_OUT = array_otp_reg;
    assign ARRAY_ADDR_OUT = array_addr_reg;
    assign RD_DONE_OUT = done_reg;
    assign RD_DATA_OUT = data_reg;
    assign RD_CLASS_OUT = class_reg;
    assign WS_LOW_OUT = ws_low_reg;

    // helper: cycles since the take and wait-states loaded then
    int elapsed;
    int ws_taken;
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            elapsed <= 0;
            ws_taken <= 0;
        end else if (take) begin
            elapsed <= 0; // counts edges from the take edge up to the done edge
            ws_taken <= int'(eff_ws);
        end else if (state_reg == S_WAIT) begin
            elapsed <= elapsed + 1;
        end
    end

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_N_IN);

    sequence s_take;
        take;
    endsequence
    sequence s_stalled;
        !REQ_READY_OUT && ARRAY_EN_OUT && !RD_DONE_OUT;
    endsequence

    a_random_ws_floor: assert property ( // [RULE_01]
        take && req_class == CLS_RANDOM |-> eff_ws >= ws_t'(1))
        else $error("random wait-states below one");
    a_paged_ws_formula: assert property ( // [RULE_02]
        take && req_class == CLS_PAGED |-> eff_ws >= ws_t'(PAGED_CEIL))
        else $error("paged wait-states below formula value");
    a_paged_time_cover: assert property ( // [RULE_03]
        take && req_class == CLS_PAGED |->
        (int'(eff_ws) + 1) * `FOWS_CLK_PERIOD_NS >= `FOWS_PAGED_ACCESS_NS)
        else $error("paged access shorter than array time");
    a_random_time_cover: assert property ( // [RULE_04]
        take && req_class == CLS_RANDOM |->
        (int'(eff_ws) + 1) * `FOWS_CLK_PERIOD_NS >= `FOWS_RANDOM_ACCESS_NS)
        else $error("random access shorter than array time");
    a_otp_time_cover: assert property ( // [RULE_05]
        take && req_class == CLS_OTP |->
        (int'(eff_ws) + 1) * `FOWS_CLK_PERIOD_NS >= `FOWS_OTP_ACCESS_NS && eff_ws >= ws_t'(1))
        else $error("otp access shorter than array time");
    a_done_latency: assert property ( // [RULE_09]
        $rose(RD_DONE_OUT) |-> elapsed == ws_taken + 1)
        else $error("read done at wrong cycle");
    a_stall_until_done: assert property ( // [RULE_09]
        s_take |=> s_stalled ##[0:16] (RD_DONE_OUT && REQ_READY_OUT && !ARRAY_EN_OUT))
        else $error("requester not stalled until done");
    a_done_single: assert property ( // [RULE_09]
        RD_DONE_OUT |=> !RD_DONE_OUT)
        else $error("done strobe longer than one cycle");
endmodule
`default_nettype wire

/* tb/flash_array_model.sv */
// behavioural model of the flash and otp arrays seen from the read sequencer
// assumes the sequencer holds address and select steady while enable is high
`default_nettype none
module flash_array_model #(
    parameter int ADDR_W = 22,
    parameter int DATA_W = 16
) (
    input wire logic clock_in,
    input wire logic en_in,
    input wire logic otp_in,
    input wire logic [ADDR_W-1:0] addr_in,
    output logic [DATA_W-1:0] data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] junk_reg = 16'h0000;
    // junk changes every cycle so a read that samples off-window data is caught
    always @(posedge clock_in) junk_reg <= junk_reg + 16'h1357;
    // both arrays are read-only here: the bench never programs, so no otp word is
    // written twice and no flash sector is reprogrammed without an erase
    // word depends on array and address; outside an access the bus carries junk
    assign data_out = en_in ? (addr_in[15:0] ^ (otp_in ? 16'h5a5a : 16'ha5a5)) : junk_reg;
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the flash/otp wait-state read sequencer
// assumes the array model answers within the same cycle as the address
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import fows_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, otp = 1'b0;
    logic [21:0] addr = 22'h000000;
    ws_cfg_t cfg = 12'h355;
    logic ready, en, a_otp, done;
    logic [21:0] a_addr;
    logic [15:0] a_data, rd_data;
    access_class_t cls;
    ws_low_t low;
    int n_fail = 0, compares = 0, cyc = 0;
    flash_otp_wait_state_access dut_u (.CLOCK_IN(clk), .RST_N_IN(rst_n), .WS_CFG_IN(cfg),
        .REQ_VALID_IN(valid), .REQ_OTP_IN(otp), .REQ_ADDR_IN(addr), .REQ_READY_OUT(ready),
        .ARRAY_EN_OUT(en), .ARRAY_OTP_OUT(a_otp), .ARRAY_ADDR_OUT(a_addr),
        .ARRAY_DATA_IN(a_data), .RD_DONE_OUT(done), .RD_DATA_OUT(rd_data),
        .RD_CLASS_OUT(cls), .WS_LOW_OUT(low));
    flash_array_model arr_u (.clock_in(clk), .en_in(en), .otp_in(a_otp), .addr_in(a_addr),
        .data_out(a_data));
    initial forever #5 clk = ~clk;
    // a hang costs one mismatch and still reaches the verdict
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("counts: compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // one read: take at the first edge, count edges until done, judge latency and word
    task automatic rd(input logic o, input logic [21:0] a, input access_class_t c, input int w);
        int n;
        n = 0;
        valid = 1'b1;
        otp = o;
        addr = a;
        @(posedge clk) #1;
        valid = 1'b0;
        chk("stall", {31'h0, ready}, 32'h0);
        while (done !== 1'b1 && n < 40) begin
            @(posedge clk) #1;
            n++;
        end
        chk("latency", n, w + 1);
        chk("class", {30'h0, cls}, {30'h0, c});
        chk("data", {16'h0, rd_data}, {16'h0, a[15:0] ^ (o ? 16'h5a5a : 16'ha5a5)});
        @(posedge clk) #1;
    endtask
    task automatic t_reset();
        chk("rst ready", {31'h0, ready}, 32'h1);
        chk("rst en", {31'h0, en}, 32'h0);
        chk("rst done", {31'h0, done}, 32'h0);
        chk("rst class", {30'h0, cls}, {30'h0, CLS_RANDOM});
        $display("test reset done");
    endtask
    // host minimum at 100 MHz, with an otp read between two reads of one page
    task automatic t_nominal();
        cfg = 12'h335;
        rd(1'b0, 22'h012340, CLS_RANDOM, 3);
        rd(1'b1, 22'h000010, CLS_OTP, 5);
        rd(1'b0, 22'h012343, CLS_PAGED, 3);
        chk("low nominal", {29'h0, low}, 32'h0);
        $display("test nominal done");
    endtask
    // zero settings are raised to the floors and flagged
    task automatic t_low();
        cfg = 12'h000;
        rd(1'b0, 22'h3fff00, CLS_RANDOM, 3);
        rd(1'b0, 22'h3fff01, CLS_PAGED, 3);
        rd(1'b1, 22'h3fffff, CLS_OTP, 5);
        chk("low flags", {29'h0, low}, 32'h7);
        $display("test low done");
    endtask
    // settings above the floors are honoured as given
    task automatic t_high();
        cfg = 12'h789;
        rd(1'b0, 22'h000100, CLS_RANDOM, 8);
        rd(1'b0, 22'h000102, CLS_PAGED, 7);
        rd(1'b1, 22'h000100, CLS_OTP, 9);
        chk("low high", {29'h0, low}, 32'h0);
        $display("test high done");
    endtask
    // a request raised while busy is dropped, not queued
    task automatic t_refused();
        int k;
        cfg = 12'h335;
        valid = 1'b1;
        addr = 22'h000200;
        otp = 1'b0;
        @(posedge clk) #1;
        addr = 22'h000300;
        @(posedge clk) #1;
        valid = 1'b0;
        k = 0;
        repeat (20) begin
            @(posedge clk) #1;
            if (done === 1'b1) k++;
        end
        chk("single done", k, 1);
        chk("kept addr", {16'h0, rd_data}, {16'h0, 16'h0200 ^ 16'ha5a5});
        $display("test refused done");
    endtask
    // a reset in mid-run closes the open page, so a read in the same page is random
    task automatic t_rereset();
        rst_n = 1'b0;
        @(posedge clk) #1;
        chk("rerst ready", {31'h0, ready}, 32'h1);
        rst_n = 1'b1;
        rd(1'b0, 22'h000201, CLS_RANDOM, 3);
        $display("test rereset done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1;
        t_reset();
        rst_n = 1'b1;
        @(posedge clk) #1;
        t_nominal();
        t_low();
        t_high();
        t_refused();
        t_rereset();
        give_verdict();
    end
endmodule
`default_nettype wire
